// ===== cpu_if_model.sv
// model of the cpu interfaces holding pending and active state per interrupt
module cpu_if_model #(
	parameter int NIRQ = 64
) (
	// clock and reset
	input  wire logic            core_clk_i,
	input  wire logic            arst_n_i,
	// state requested by the bench
	input  wire logic [NIRQ-1:0] set_pend_i,
	input  wire logic [NIRQ-1:0] set_act_i,
	// state seen by the distributor
	output logic      [NIRQ-1:0] pending_o,
	output logic      [NIRQ-1:0] active_o
);
	// state follows one edge late, as a real interface acknowledges it
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pending_o <= '0;
			active_o  <= '0;
		end else begin
			pending_o <= set_pend_i;
			active_o  <= set_act_i;
		end
	end
endmodule : cpu_if_model

// ===== irq_target_and_trigger_config.sv
// register logic for per-interrupt processor targets and trigger type, with AHB-Lite slave
//
// Local design decision: the AHB-Lite slave port.
`include "irq_tgt_cfg.svh"

// Behaviour
// - eight-bit target list kept per interrupt
// - bit k of list selects interface k
// - target lists accept byte accesses
// - unimplemented interrupt fields read zero, ignore writes
// - interrupts 0-31 targets read-only, show reader
// - hardware-fixed shared targets read-only, return fixed
// - secure-group fields hidden from non-secure access
// - lockdown freezes secure lockable shared fields
// - single processor build: targets read zero
// - eight target registers per line group
// - private target registers banked per processor
// - target list at 0x800 plus index
// - absent interface bits read zero, ignore writes
// - writes any time, active never cancelled
// - pending follows target list changes
// - active and pending holds old targets
// - two-bit trigger field, upper bit edge
// - software interrupt trigger reads two (edge), read-only
// - shared trigger writable, reads true type
// - lower bit selects handling model early
// - trigger field at 0xC00 plus index divided by four
// - private trigger register banked per processor
module irq_target_and_trigger_config #(
	parameter int CPU_NUM      = 4,
	parameter int LINE_GROUPS  = 2,
	parameter int PPI_TRG_WR   = 1,
	parameter int MODEL_BIT_EN = 0,
	parameter logic [LINE_GROUPS*32-1:0] FIXED_SPI  = '0,
	parameter logic [7:0]                FIXED_MASK = 8'h01,
	parameter logic [LINE_GROUPS*32-1:0] LOCKABLE   = '0
) (
	// clock, reset, enable
	input  wire logic                         core_clk_i,
	input  wire logic                         arst_n_i,
	input  wire logic                         clk_en_i,
	// ahb-lite slave
	input  wire logic                         hsel_i,
	input  wire logic [11:0]                  haddr_i,
	input  wire irq_tgt_pkg::htrans_t         htrans_i,
	input  wire logic                         hwrite_i,
	input  wire logic [2:0]                   hsize_i,
	input  wire logic [31:0]                  hwdata_i,
	input  wire logic                         hready_i,
	input  wire logic [2:0]                   hmaster_i,
	input  wire logic                         hnonsec_i,
	output logic [31:0]                       hrdata_o,
	output logic                              hreadyout_o,
	output logic                              hresp_o,
	// distributor state
	input  wire logic [LINE_GROUPS*32-1:0]    secure_grp_i,
	input  wire logic                         lockdown_i,
	input  wire logic [LINE_GROUPS*32-1:0]    pending_i,
	input  wire logic [LINE_GROUPS*32-1:0]    active_i,
	// forwarding view for cpu interfaces
	output logic [LINE_GROUPS*32*8-1:0]       eff_targets_o,
	output logic [LINE_GROUPS*32-1:0]         edge_trig_o
);
	import irq_tgt_pkg::*;

	localparam int NIRQ = LINE_GROUPS * 32;
	localparam cpu_mask_t CPU_BITS = cpu_mask_t'((9'h001 << CPU_NUM) - 9'h001);
	// probe interrupts for the checks at the bottom; the bench exercises these
	localparam int NS_PROBE   = `PRIV_COUNT;
	localparam int LOCK_PROBE = `PRIV_COUNT + 4;

	// shared interrupt targets and trigger bits, banked private trigger bits
	cpu_mask_t  tgt_reg [NIRQ];
	logic [1:0] trg_reg [NIRQ];
	logic [15:0][1:0] ppi_trg_reg [8];
	bus_state_t st_reg;
	logic [11:0] addr_reg;
	logic [3:0]  lane_reg;
	logic [2:0]  cpu_reg;
	logic        ns_reg;

	// byte lanes from size and address
	function automatic logic [3:0] lanes(input logic [2:0] sz, input logic [1:0] a);
		logic [3:0] l;
		l = 4'hF;
		if (sz == 3'h0)
			l = 4'h1 << a;
		else if (sz == 3'h1)
			l = a[1] ? 4'hC : 4'h3;
		return l;
	endfunction : lanes

	// field is accessible to this request
	function automatic logic may_touch(input int m, input logic ns);
		return (m < NIRQ) && !(ns && secure_grp_i[m]);
	endfunction : may_touch

	wire take = hsel_i && hready_i && htrans_i[1] && clk_en_i;

	// address phase capture; write data lands one phase later
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_reg   <= ST_IDLE;
			addr_reg <= 12'h000;
			lane_reg <= 4'h0;
			cpu_reg  <= 3'h0;
			ns_reg   <= 1'b0;
		end else if (clk_en_i) begin
			st_reg <= ST_IDLE;
			if (take) begin
				st_reg   <= hwrite_i ? ST_WRITE : ST_IDLE;
				addr_reg <= {haddr_i[11:2], 2'b00};
				lane_reg <= lanes(hsize_i, haddr_i[1:0]);
				cpu_reg  <= hmaster_i;
				ns_reg   <= hnonsec_i;
			end
		end
	end

	// read data for the addressed word, computed in address phase
	logic [31:0] rd_next;
	always_comb begin
		int m;
		rd_next = 32'h0;
		m = 0;
		if (haddr_i >= `TGT_BASE && haddr_i < `TGT_BASE + `TGT_SPAN && CPU_NUM > 1) begin
			for (int b = 0; b < 4; b++) begin
				m = 4 * int'((haddr_i - `TGT_BASE) >> 2) + b;
				if (may_touch(m, hnonsec_i)) begin
					if (m < `PRIV_COUNT)
						rd_next[8*b +: 8] = cpu_mask_t'(8'h01 << hmaster_i) & CPU_BITS;
					else if (FIXED_SPI[m])
						rd_next[8*b +: 8] = FIXED_MASK & CPU_BITS;
					else
						rd_next[8*b +: 8] = tgt_reg[m] & CPU_BITS;
				end
			end
		end else if (haddr_i >= `TRG_BASE && haddr_i < `TRG_BASE + `TRG_SPAN) begin
			for (int f = 0; f < 16; f++) begin
				m = 16 * int'((haddr_i - `TRG_BASE) >> 2) + f;
				if (may_touch(m, hnonsec_i)) begin
					if (m < `SGI_COUNT)
						rd_next[2*f +: 2] = `TRG_SGI_VALUE;
					else if (m < `PRIV_COUNT && PPI_TRG_WR != 0)
						rd_next[2*f +: 2] = ppi_trg_reg[hmaster_i][m-16];
					else
						rd_next[2*f +: 2] = trg_reg[m];
				end
			end
		end
	end

	// read data register and ready; always zero wait, always OKAY
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			hrdata_o    <= 32'h0;
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
		end else if (clk_en_i && take && !hwrite_i) begin
			hrdata_o <= rd_next;
		end
	end

	// target list writes, shared interrupts only, byte lanes kept apart
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int i = 0; i < NIRQ; i++)
				tgt_reg[i] <= `TGT_RESET;
		end else if (clk_en_i && st_reg == ST_WRITE && CPU_NUM > 1 &&
			addr_reg >= `TGT_BASE && addr_reg < `TGT_BASE + `TGT_SPAN) begin
			for (int b = 0; b < 4; b++) begin
				int m;
				m = 4 * int'((addr_reg - `TGT_BASE) >> 2) + b;
				if (lane_reg[b] && may_touch(m, ns_reg) && m >= `PRIV_COUNT &&
					!FIXED_SPI[m] && !(lockdown_i && LOCKABLE[m] && secure_grp_i[m]))
					tgt_reg[m] <= hwdata_i[8*b +: 8] & CPU_BITS;
			end
		end
	end

	// trigger writes; lower bit stored only where the model choice exists
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int i = 0; i < NIRQ; i++)
				trg_reg[i] <= `TRG_RESET;
			for (int c = 0; c < 8; c++)
				ppi_trg_reg[c] <= '0;
		end else if (clk_en_i && st_reg == ST_WRITE &&
			addr_reg >= `TRG_BASE && addr_reg < `TRG_BASE + `TRG_SPAN) begin
			for (int f = 0; f < 16; f++) begin
				int m;
				logic [1:0] v;
				m = 16 * int'((addr_reg - `TRG_BASE) >> 2) + f;
				v = {hwdata_i[2*f+1], MODEL_BIT_EN != 0 ? hwdata_i[2*f] : 1'b0};
				if (lane_reg[f/4] && may_touch(m, ns_reg) && m >= `SGI_COUNT &&
					!(lockdown_i && LOCKABLE[m] && secure_grp_i[m])) begin
					if (m < `PRIV_COUNT) begin
						if (PPI_TRG_WR != 0)
							ppi_trg_reg[cpu_reg][m-16] <= v;
					end else
						trg_reg[m] <= v;
				end
			end
		end
	end

	// forwarding view: old targets held while active and pending
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			eff_targets_o <= '0;
			edge_trig_o   <= '0;
		end else if (clk_en_i) begin
			for (int m = 0; m < NIRQ; m++) begin
				if (m < `SGI_COUNT)
					edge_trig_o[m] <= 1'b1;
				else if (m < `PRIV_COUNT)
					edge_trig_o[m] <= PPI_TRG_WR != 0 ? ppi_trg_reg[0][m-16][`TRG_EDGE_BIT]
						: trg_reg[m][`TRG_EDGE_BIT];
				else
					edge_trig_o[m] <= trg_reg[m][`TRG_EDGE_BIT];
				if (CPU_NUM < 2 || m < `PRIV_COUNT)
					eff_targets_o[8*m +: 8] <= CPU_BITS;
				else if (!(active_i[m] && pending_i[m]))
					eff_targets_o[8*m +: 8] <= FIXED_SPI[m] ? FIXED_MASK & CPU_BITS
						: tgt_reg[m] & CPU_BITS;
			end
		end
	end

	// checker helper: view before the last enabled edge and what was held then
	logic [NIRQ-1:0]   hold_reg;
	logic [NIRQ*8-1:0] eff_prev_reg;
	logic              held_moved;
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			hold_reg     <= '0;
			eff_prev_reg <= '0;
		end else if (clk_en_i) begin
			hold_reg     <= active_i & pending_i;
			eff_prev_reg <= eff_targets_o;
		end
	end

	// any shared interrupt that was held must show the same list
	always_comb begin
		held_moved = 1'b0;
		for (int m = `PRIV_COUNT; m < NIRQ; m++) begin
			if (hold_reg[m] && eff_targets_o[8*m +: 8] != eff_prev_reg[8*m +: 8])
				held_moved = 1'b1;
		end
	end

	// writes never stall; target change seen one cycle later
	a_bus_ready: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		hreadyout_o && !hresp_o) else $error("slave stalled or errored");
	// the first edge after reset has not refreshed the view yet
	a_sgi_trig_edge: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		$past(clk_en_i) && $past(arst_n_i) |-> edge_trig_o[0]) else $error("sgi not edge");
	// every held shared interrupt keeps its whole list, not just the top one
	a_held_any: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		!held_moved) else $error("held targets moved");
	// a free shared interrupt that is not hardware-fixed shows its stored list one edge later
	a_eff_follow: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		clk_en_i && !(active_i[NS_PROBE] && pending_i[NS_PROBE]) && CPU_NUM > 1 &&
		!FIXED_SPI[NS_PROBE] |=>
		eff_targets_o[8*NS_PROBE +: 8] == $past(tgt_reg[NS_PROBE] & CPU_BITS))
		else $error("targets not followed");
	// private interrupts reach every present processor
	a_priv_eff_all: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		$past(arst_n_i) && $past(clk_en_i) |-> eff_targets_o[7:0] == CPU_BITS)
		else $error("private targets wrong");
	// stored lists never hold bits of absent interfaces
	a_tgt_masked: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		(tgt_reg[NS_PROBE] & ~CPU_BITS) == 8'h00) else $error("absent bit stored");
	// private lists are never written
	a_priv_list_const: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		$stable(tgt_reg[0])) else $error("private list written");
	// software interrupt trigger storage stays untouched
	a_sgi_trg_const: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		trg_reg[0] == `TRG_RESET) else $error("sgi trigger written");
	// without the model choice the lower bit stays clear
	a_model_bit: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		MODEL_BIT_EN == 0 |-> trg_reg[NIRQ-1][0] == 1'b0) else $error("model bit kept");
	// read data stands until the next read is taken
	a_rd_hold: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		!(clk_en_i && take && !hwrite_i) |=> $stable(hrdata_o))
		else $error("read data moved");
	// locked secure shared fields do not move
	a_lock_freeze: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		clk_en_i && lockdown_i && LOCKABLE[LOCK_PROBE] && secure_grp_i[LOCK_PROBE] |=>
		$stable(tgt_reg[LOCK_PROBE]) && $stable(trg_reg[LOCK_PROBE]))
		else $error("locked field moved");
	// non-secure writes leave secure lists alone
	a_ns_wr_blocked: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		clk_en_i && st_reg == ST_WRITE && ns_reg && secure_grp_i[NS_PROBE] |=>
		$stable(tgt_reg[NS_PROBE])) else $error("secure list written");
	// forwarded trigger type follows the stored upper bit
	a_edge_spi: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		$past(arst_n_i) && $past(clk_en_i) |->
		edge_trig_o[NIRQ-1] == $past(trg_reg[NIRQ-1][`TRG_EDGE_BIT]))
		else $error("trigger type wrong");
	// private trigger view comes from the first processor's bank
	a_ppi_bank0: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		$past(arst_n_i) && $past(clk_en_i) && PPI_TRG_WR != 0 |->
		edge_trig_o[16] == $past(ppi_trg_reg[0][0][`TRG_EDGE_BIT]))
		else $error("private trigger wrong");
	// a byte write to another lane leaves this list alone
	a_lane_kept: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		clk_en_i && st_reg == ST_WRITE && addr_reg == `TGT_BASE + 12'(NS_PROBE) &&
		!lane_reg[0] |=> $stable(tgt_reg[NS_PROBE])) else $error("other lane hit");
	// unmapped words read zero
	a_unmapped_zero: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		take && !hwrite_i && haddr_i == 12'h000 |=>
		hrdata_o == 32'h0) else $error("unmapped not zero");
	// trigger words past the last line group read zero
	a_oob_trg: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		take && !hwrite_i && haddr_i == `TRG_BASE + 12'(NIRQ/4) |=>
		hrdata_o == 32'h0) else $error("unimplemented trigger not zero");
	a_held_targets: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		clk_en_i && active_i[NIRQ-1] && pending_i[NIRQ-1] |=>
		$stable(eff_targets_o[8*(NIRQ-1) +: 8])) else $error("targets moved");
	a_absent_cpu: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		(eff_targets_o[8*(NIRQ-1) +: 8] & ~CPU_BITS) == 8'h00) else $error("absent cpu");
	a_priv_read: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		take && !hwrite_i && haddr_i == `TGT_BASE && !hnonsec_i && CPU_NUM > 1 |=>
		hrdata_o[7:0] == (cpu_mask_t'(8'h01 << $past(hmaster_i)) & CPU_BITS))
		else $error("private target read");
	a_sgi_cfg_read: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		take && !hwrite_i && haddr_i == `TRG_BASE && !hnonsec_i |=>
		hrdata_o[1:0] == `TRG_SGI_VALUE) else $error("sgi trigger read");
	a_ns_hidden: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		take && !hwrite_i && hnonsec_i && haddr_i == `TRG_BASE && secure_grp_i[0] |=>
		hrdata_o[1:0] == 2'h0) else $error("secure field visible");
	a_oob_zero: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
		take && !hwrite_i && haddr_i == `TGT_BASE + 12'(NIRQ) |=>
		hrdata_o == 32'h0) else $error("unimplemented not zero");
endmodule : irq_target_and_trigger_config

// ===== irq_tgt_cfg.svh
// offsets, field positions, reset values and timing counts for the target and trigger block
`ifndef IRQ_TGT_CFG_SVH
`define IRQ_TGT_CFG_SVH
`define TGT_BASE          12'h800
`define TRG_BASE          12'hC00
`define TGT_SPAN          12'h400
`define TRG_SPAN          12'h100
`define SGI_COUNT         16
`define PRIV_COUNT        32
`define TGT_RESET         8'h01
`define TRG_RESET         2'h0
`define TRG_SGI_VALUE     2'h2
`define TRG_EDGE_BIT      1
`define TGT_SETTLE_NS     25
`define TGT_SETTLE_CYC    ((`TGT_SETTLE_NS + 24) / 25)
`endif

// ===== irq_tgt_pkg.sv
// types shared by the target and trigger block
package irq_tgt_pkg;
	typedef logic [7:0] cpu_mask_t;
	typedef logic [1:0] htrans_t;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_WRITE = 2'b01
	} bus_state_t;
endpackage : irq_tgt_pkg

// ===== tb_irq_target_and_trigger_config.sv
// self-checking bench for the target and trigger register block
module tb_irq_target_and_trigger_config;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, arst_n, hsel, hwrite, hnonsec, hrdy, hresp, lock;
	logic [11:0] haddr;
	logic [1:0]  htrans;
	logic [2:0]  hsize, hmaster;
	logic [31:0] hwdata, hrdata, rd;
	logic [63:0] sec_grp, pend, act, set_pend, set_act, edge_trig;
	logic [511:0] eff;
	int          num_errors, check_count;

	irq_target_and_trigger_config #(.LOCKABLE(64'h10_0000_0000)) uut (.core_clk_i(clk),
		.arst_n_i(arst_n), .clk_en_i(1'b1),
		.hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
		.hwdata_i(hwdata), .hready_i(hrdy), .hmaster_i(hmaster), .hnonsec_i(hnonsec),
		.hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .secure_grp_i(sec_grp),
		.lockdown_i(lock), .pending_i(pend), .active_i(act), .eff_targets_o(eff),
		.edge_trig_o(edge_trig));
	cpu_if_model cpus (.core_clk_i(clk), .arst_n_i(arst_n), .set_pend_i(set_pend),
		.set_act_i(set_act), .pending_o(pend), .active_o(act));

	// one single ahb-lite transfer, waiting on the slave's ready
	task automatic bus(input logic w, input logic [11:0] a, input logic [2:0] sz,
		input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= sz;
		do @(posedge clk); while (hrdy !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hrdy !== 1'b1);
		rd = hrdata;
	endtask : bus
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
			num_errors++;
		end
	endtask : chk
	task automatic settle();
		repeat (2) @(posedge clk);
	endtask : settle
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish

	task automatic t_reset();
		bus(0, 12'hC00, 3'h2, 32'h0);
		chk("trig0", 32'hAAAAAAAA, rd);
		bus(0, 12'h820, 3'h2, 32'h0);
		chk("tgt8", 32'h01010101, rd);
		chk("eff32", 32'h01, {24'h0, eff[256+:8]});
		bus(0, 12'h840, 3'h2, 32'h0);
		chk("tgt_unimpl", 32'h0, rd);
		bus(0, 12'hC10, 3'h2, 32'h0);
		chk("trg_unimpl", 32'h0, rd);
		bus(0, 12'h000, 3'h2, 32'h0);
		chk("unmapped", 32'h0, rd);
		$display("test reset done");
	endtask : t_reset
	task automatic t_targets();
		bus(1, 12'h820, 3'h2, 32'hFFFFFFFF);
		bus(0, 12'h820, 3'h2, 32'h0);
		chk("tgt_mask", 32'h0F0F0F0F, rd);
		bus(1, 12'h821, 3'h0, 32'h00000300);
		bus(0, 12'h820, 3'h2, 32'h0);
		chk("tgt_byte", 32'h0F0F030F, rd);
		settle();
		chk("eff33", 32'h03, {24'h0, eff[264+:8]});
		$display("test targets done");
	endtask : t_targets
	task automatic t_private();
		hmaster <= 3'h2;
		bus(1, 12'h800, 3'h2, 32'hFFFFFFFF);
		bus(0, 12'h800, 3'h2, 32'h0);
		chk("tgt_priv", 32'h04040404, rd);
		hmaster <= 3'h0;
		$display("test private done");
	endtask : t_private
	task automatic t_secure();
		sec_grp <= 64'h1_0000_0001;
		hnonsec <= 1'b1;
		bus(0, 12'h820, 3'h2, 32'h0);
		chk("ns_read", 32'h0F0F0300, rd);
		bus(0, 12'hC00, 3'h2, 32'h0);
		chk("ns_sgi_cfg", 32'hAAAAAAA8, rd);
		bus(1, 12'h820, 3'h2, 32'h0);
		hnonsec <= 1'b0;
		bus(0, 12'h820, 3'h2, 32'h0);
		chk("ns_write", 32'h0000000F, rd);
		$display("test secure done");
	endtask : t_secure
	task automatic t_trigger();
		// no enable lives in this block; the fields under test feed no live interrupt
		bus(1, 12'hC08, 3'h2, 32'hFFFFFFFF);
		bus(0, 12'hC08, 3'h2, 32'h0);
		chk("trg_spi", 32'hAAAAAAAA, rd);
		settle();
		chk("edge", 32'hFFFF, {16'h0, edge_trig[47:32]});
		bus(1, 12'hC00, 3'h2, 32'h0);
		bus(0, 12'hC00, 3'h2, 32'h0);
		chk("trg_sgi", 32'hAAAAAAAA, rd);
		$display("test trigger done");
	endtask : t_trigger
	task automatic t_active();
		set_pend <= 64'h4_0000_0000;
		set_act <= 64'h4_0000_0000;
		settle();
		bus(1, 12'h822, 3'h0, 32'h00020000);
		settle();
		chk("eff_held", 32'h00, {24'h0, eff[272+:8]});
		set_act <= 64'h0;
		repeat (3) @(posedge clk);
		chk("eff_moved", 32'h02, {24'h0, eff[272+:8]});
		$display("test active done");
	endtask : t_active
	task automatic t_lock();
		sec_grp <= 64'h11_0000_0001;
		lock <= 1'b1;
		bus(1, 12'h824, 3'h2, 32'h0000000F);
		bus(0, 12'h824, 3'h2, 32'h0);
		chk("tgt_locked", 32'h00000001, rd);
		lock <= 1'b0;
		bus(1, 12'h824, 3'h2, 32'h0000000F);
		bus(0, 12'h824, 3'h2, 32'h0);
		chk("tgt_unlocked", 32'h0000000F, rd);
		$display("test lockdown done");
	endtask : t_lock

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		#500us;
		num_errors++;
		tally_and_finish();
	end
	initial begin
		{arst_n, hsel, hwrite, hnonsec, haddr, htrans, hsize, hmaster, lock} = '0;
		{hwdata, sec_grp, set_pend, set_act} = '0;
		num_errors = 0;
		check_count = 0;
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		t_reset();
		t_targets();
		t_private();
		t_secure();
		t_trigger();
		t_active();
		t_lock();
		tally_and_finish();
	end
endmodule : tb_irq_target_and_trigger_config
